// ==== pkg/pug_defines.svh ====
// register offsets, field positions, reset values of the pin unit global block
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`ifndef PUG_DEFINES_SVH
`define PUG_DEFINES_SVH

`define PUG_ADDR_W 8
`define PUG_OFF_SUMMARY 8'h00
`define PUG_OFF_GLOBAL 8'h04
`define PUG_OFF_SCAN_IN 8'h08
`define PUG_OFF_SCAN_OUT 8'h0c
`define PUG_OFF_IRQ_STAT 8'h10
`define PUG_OFF_IRQ_MASK 8'h14
`define PUG_OFF_BANK0 8'h20
`define PUG_OFF_BANK_LAST 8'h3c

`define PUG_GLB_SWAP_BIT 0
`define PUG_GLB_CLKG_BIT 1
`define PUG_DIR_OVR_BIT 6
`define PUG_PULL_LSB 2
`define PUG_PULL_MSB 3
`define PUG_WEAK_BIT 4

`define PUG_GLB_MASK 16'h0003
`define PUG_SCAN_IN_MASK 16'h004c
`define PUG_SCAN_OUT_MASK 16'h0050
`define PUG_GLB_RESET 16'h0002
`define PUG_SCAN_IN_RESET 16'h0000
`define PUG_SCAN_OUT_RESET 16'h0000

`define PUG_PORTS 8
`define PUG_PINS 16

`endif

// ==== pkg/pug_pkg.sv ====
// types shared by the pin unit global block
// assumes nothing beyond the defines header
package pug_pkg;

    typedef enum logic [1:0] {
        PUG_PULL_OFF_A = 2'h0,
        PUG_PULL_OFF_B = 2'h1,
        PUG_PULL_DOWN = 2'h2,
        PUG_PULL_UP = 2'h3
    } pug_pull_t;

    typedef enum logic [1:0] {
        PUG_RESP_OKAY = 2'h0,
        PUG_RESP_SLVERR = 2'h2
    } pug_resp_t;

endpackage

// ==== hw/pug_flag_bank.sv ====
// pin event flags for all ports, set by event pulses, cleared by write-one
// assumes event pulses come from port logic on clk_i
`timescale 1ns/1ps
`include "pug_defines.svh"

module pug_flag_bank
    import pug_pkg::*;
#(
    parameter int PORTS = `PUG_PORTS,
    parameter int PINS = `PUG_PINS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [PORTS*PINS-1:0] pin_event_i,
    input wire logic clr_we_i,
    input wire logic [$clog2(PORTS)-1:0] clr_port_i,
    input wire logic [PINS-1:0] clr_mask_i,
    output logic [PORTS*PINS-1:0] pin_event_flag_o,
    output logic [PORTS-1:0] port_any_event_flag_o
);

    localparam int PW = $clog2(PORTS);

    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            // one register per port so each has a single writing process
            logic [PINS-1:0] flag_q;
            wire [PINS-1:0] ev = pin_event_i[p*PINS +: PINS];
            wire hit = clr_we_i && (clr_port_i == PW'(p));
            wire [PINS-1:0] clr = hit ? clr_mask_i : {PINS{1'b0}};
            // a new event in the clearing cycle survives
            wire [PINS-1:0] nxt = (flag_q & ~clr) | ev;
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    flag_q <= {PINS{1'b0}};
                end else if (ce_i) begin
                    flag_q <= nxt;
                end
            end
            assign pin_event_flag_o[p*PINS +: PINS] = flag_q;
            assign port_any_event_flag_o[p] = |flag_q;
        end
    endgenerate

endmodule

// ==== hw/pug_top.sv ====
// pin unit global control: flag summary, global setup, scan pin setup
// assumes AXI4-Lite master on clk_i, scan pads asynchronous to clk_i
`timescale 1ns/1ps
`include "pug_defines.svh"

module pug_top
    import pug_pkg::*;
#(
    parameter int PORTS = `PUG_PORTS,
    parameter int PINS = `PUG_PINS,
    parameter bit HAS_SWAP_PORT = 1'b1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // axi4-lite slave
    input wire logic [`PUG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PUG_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pin event pulses from port logic on clk_i
    input wire logic [PORTS*PINS-1:0] pin_event_i,
    output logic [PORTS*PINS-1:0] pin_event_flag_o,
    output logic irq_o,
    // global controls
    output logic ext_bus_clock_gate_o,
    output logic port_swap_select_o,
    // scan data input pad
    input wire logic scan_in_pad_i,
    output logic scan_in_pad_o,
    output logic scan_in_pad_oe_o,
    output logic scan_in_pull_en_o,
    output logic scan_in_pull_up_o,
    output logic scan_in_func_en_o,
    output logic scan_in_data_o,
    // scan data output pad
    input wire logic scan_out_data_i,
    input wire logic scan_out_drive_i,
    input wire logic scan_out_pad_i,
    output logic scan_out_pad_o,
    output logic scan_out_pad_oe_o,
    output logic scan_out_weak_drive_o,
    output logic scan_out_func_en_o
);

    localparam int PW = $clog2(PORTS);

    // register state
    logic [15:0] glb_q;
    logic [15:0] sin_q;
    logic [15:0] sout_q;
    logic [PORTS-1:0] irq_stat_q;
    logic [PORTS-1:0] irq_mask_q;

    // write channel state
    logic aw_have_q;
    logic w_have_q;
    logic [`PUG_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    // read channel state
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // pad synchronisers and registered pad drive
    logic sin_meta_q;
    logic sin_sync_q;
    logic sout_meta_q;
    logic sout_sync_q;
    logic sin_data_q;
    logic sout_pad_q;

    logic [PORTS-1:0] port_any;

    // handshakes
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire [`PUG_ADDR_W-1:0] wr_addr = aw_hs ? s_axi_awaddr : aw_addr_q;
    wire [31:0] wr_data = w_hs ? s_axi_wdata : w_data_q;
    wire [3:0] wr_strb = w_hs ? s_axi_wstrb : w_strb_q;
    wire aw_ok = aw_hs || aw_have_q;
    wire w_ok = w_hs || w_have_q;
    wire wr_fire = ce_i && aw_ok && w_ok && !bvalid_q;

    assign s_axi_awready = ce_i && !aw_have_q && !bvalid_q;
    assign s_axi_wready = ce_i && !w_have_q && !bvalid_q;
    assign s_axi_arready = ce_i && !rvalid_q;

    // byte lanes onto the 16-bit registers
    wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [15:0] wr_bits = wr_data[15:0] & lane_mask;

    // write decode
    wire wa_word = (wr_addr[1:0] == 2'h0);
    wire wa_summary = wa_word && (wr_addr == `PUG_OFF_SUMMARY);
    wire wa_global = wa_word && (wr_addr == `PUG_OFF_GLOBAL);
    wire wa_sin = wa_word && (wr_addr == `PUG_OFF_SCAN_IN);
    wire wa_sout = wa_word && (wr_addr == `PUG_OFF_SCAN_OUT);
    wire wa_stat = wa_word && (wr_addr == `PUG_OFF_IRQ_STAT);
    wire wa_mask = wa_word && (wr_addr == `PUG_OFF_IRQ_MASK);
    wire [`PUG_ADDR_W-1:0] wa_rel = wr_addr - `PUG_OFF_BANK0;
    wire [`PUG_ADDR_W-3:0] wa_idx = wa_rel[`PUG_ADDR_W-1:2];
    wire wa_bank_rng = (wr_addr >= `PUG_OFF_BANK0) && (wr_addr <= `PUG_OFF_BANK_LAST);
    wire wa_bank = wa_word && wa_bank_rng && (int'(wa_idx) < PORTS);
    wire wa_hit = wa_summary || wa_global || wa_sin || wa_sout || wa_stat || wa_mask
        || wa_bank;

    // read decode
    wire ra_word = (s_axi_araddr[1:0] == 2'h0);
    wire ra_summary = ra_word && (s_axi_araddr == `PUG_OFF_SUMMARY);
    wire ra_global = ra_word && (s_axi_araddr == `PUG_OFF_GLOBAL);
    wire ra_sin = ra_word && (s_axi_araddr == `PUG_OFF_SCAN_IN);
    wire ra_sout = ra_word && (s_axi_araddr == `PUG_OFF_SCAN_OUT);
    wire ra_stat = ra_word && (s_axi_araddr == `PUG_OFF_IRQ_STAT);
    wire ra_mask = ra_word && (s_axi_araddr == `PUG_OFF_IRQ_MASK);
    wire [`PUG_ADDR_W-1:0] ra_rel = s_axi_araddr - `PUG_OFF_BANK0;
    wire [`PUG_ADDR_W-3:0] ra_idx = ra_rel[`PUG_ADDR_W-1:2];
    wire ra_bank_rng = (s_axi_araddr >= `PUG_OFF_BANK0)
        && (s_axi_araddr <= `PUG_OFF_BANK_LAST);
    wire ra_bank = ra_word && ra_bank_rng && (int'(ra_idx) < PORTS);
    wire ra_hit = ra_summary || ra_global || ra_sin || ra_sout || ra_stat || ra_mask
        || ra_bank;

    // summary carries only the port bits, upper half reads zero
    wire [15:0] summary_val = {{(16-PORTS){1'b0}}, port_any};
    wire [PINS-1:0] bank_val = pin_event_flag_o[PW'(ra_idx)*PINS +: PINS];

    wire [15:0] rd_val =
        ra_summary ? summary_val :
        ra_global ? glb_q :
        ra_sin ? sin_q :
        ra_sout ? sout_q :
        ra_stat ? {{(16-PORTS){1'b0}}, irq_stat_q} :
        ra_mask ? {{(16-PORTS){1'b0}}, irq_mask_q} :
        ra_bank ? 16'(bank_val) :
        16'h0000;

    // flag clears reach the bank in the cycle the write completes
    wire bank_clr = wr_fire && wa_bank;

    pug_flag_bank #(
        .PORTS(PORTS),
        .PINS(PINS)
    ) u_flags (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .pin_event_i(pin_event_i),
        .clr_we_i(bank_clr),
        .clr_port_i(PW'(wa_idx)),
        .clr_mask_i(wr_bits[PINS-1:0]),
        .pin_event_flag_o(pin_event_flag_o),
        .port_any_event_flag_o(port_any)
    );

    // per-port event seen this cycle feeds the sticky status
    logic [PORTS-1:0] port_event;
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_evt
            assign port_event[g] = |pin_event_i[g*PINS +: PINS];
        end
    endgenerate

    wire [PORTS-1:0] stat_clr = (wr_fire && wa_stat) ? wr_bits[PORTS-1:0] : '0;
    // set beats clear so an event during the clear is kept
    wire [PORTS-1:0] irq_stat_d = (irq_stat_q & ~stat_clr) | port_event;

    // masked writes, reserved bits never stored
    wire [15:0] glb_d = (glb_q & ~lane_mask) | (wr_bits & `PUG_GLB_MASK);
    wire [15:0] sin_d = (sin_q & ~lane_mask) | (wr_bits & `PUG_SCAN_IN_MASK);
    wire [15:0] sout_d = (sout_q & ~lane_mask) | (wr_bits & `PUG_SCAN_OUT_MASK);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            glb_q <= `PUG_GLB_RESET;
            sin_q <= `PUG_SCAN_IN_RESET;
            sout_q <= `PUG_SCAN_OUT_RESET;
            irq_mask_q <= '0;
            irq_stat_q <= '0;
        end else if (ce_i) begin
            // summary writes fall through with no effect
            if (wr_fire && wa_global) begin
                glb_q <= glb_d;
            end
            if (wr_fire && wa_sin) begin
                sin_q <= sin_d;
            end
            if (wr_fire && wa_sout) begin
                sout_q <= sout_d;
            end
            if (wr_fire && wa_mask) begin
                irq_mask_q <= (irq_mask_q & ~lane_mask[PORTS-1:0]) | wr_bits[PORTS-1:0];
            end
            irq_stat_q <= irq_stat_d;
        end
    end

    // write channel: address and data in either order
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= PUG_RESP_OKAY;
        end else if (ce_i) begin
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wa_hit ? PUG_RESP_OKAY : PUG_RESP_SLVERR;
            end else begin
                if (aw_hs) begin
                    aw_have_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_hs) begin
                    w_have_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // read channel: one cycle to data
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= PUG_RESP_OKAY;
        end else if (ce_i) begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= {16'h0000, rd_val};
                rresp_q <= ra_hit ? PUG_RESP_OKAY : PUG_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // global controls
    // clock gate is an enable for the cell beside the bus unit, not a gated clock
    assign ext_bus_clock_gate_o = glb_q[`PUG_GLB_CLKG_BIT];
    // without the second port the swap stays at the default map
    assign port_swap_select_o = HAS_SWAP_PORT && glb_q[`PUG_GLB_SWAP_BIT];

    // scan input pin
    wire sin_ovr = sin_q[`PUG_DIR_OVR_BIT];
    pug_pull_t sin_pull;
    assign sin_pull = pug_pull_t'(sin_q[`PUG_PULL_MSB:`PUG_PULL_LSB]);
    wire sin_pull_on = (sin_pull == PUG_PULL_DOWN) || (sin_pull == PUG_PULL_UP);

    assign scan_in_pad_oe_o = sin_ovr;
    assign scan_in_pad_o = 1'b0;
    assign scan_in_func_en_o = !sin_ovr;
    assign scan_in_pull_en_o = sin_pull_on && !sin_ovr;
    assign scan_in_pull_up_o = (sin_pull == PUG_PULL_UP) && !sin_ovr;
    assign scan_in_data_o = sin_data_q;

    // scan output pin; while enabled the scan logic owns the drive
    wire sout_ovr = sout_q[`PUG_DIR_OVR_BIT];
    assign scan_out_func_en_o = !sout_ovr;
    assign scan_out_pad_oe_o = scan_out_drive_i && !sout_ovr;
    assign scan_out_pad_o = sout_pad_q;
    assign scan_out_weak_drive_o = sout_q[`PUG_WEAK_BIT] && scan_out_pad_oe_o;

    // pads are asynchronous, two flops before use
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sin_meta_q <= 1'b0;
            sin_sync_q <= 1'b0;
            sout_meta_q <= 1'b0;
            sout_sync_q <= 1'b0;
        end else if (ce_i) begin
            sin_meta_q <= scan_in_pad_i;
            sin_sync_q <= sin_meta_q;
            sout_meta_q <= scan_out_pad_i;
            sout_sync_q <= sout_meta_q;
        end
    end

    // overridden pins hand nothing to the scan logic
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sin_data_q <= 1'b0;
            sout_pad_q <= 1'b0;
        end else if (ce_i) begin
            sin_data_q <= sin_sync_q && !sin_ovr;
            sout_pad_q <= scan_out_data_i && !sout_ovr;
        end
    end

    // the scan-out pad level is ignored whatever the override says
    wire unused_ok = &{1'b0, sout_sync_q, s_axi_awprot, s_axi_arprot, s_axi_wdata[31:16],
        s_axi_wstrb[3:2], wr_data[31:16], wr_strb[3:2]};

endmodule

// ==== tb/pug_pad_model.sv ====
// board side of the two scan pads: pull devices and release
// assumes the pad controls of pug_top on the same clock
`timescale 1ns/1ps

module pug_pad_model (
    input wire logic clk_i,
    input wire logic in_drv_i,
    input wire logic in_oe_i,
    input wire logic pull_en_i,
    input wire logic pull_up_i,
    input wire logic out_drv_i,
    input wire logic out_oe_i,
    output logic in_pad_o,
    output logic out_pad_o
);
    logic flip_q = 1'b0;

    // an undriven pad with no pull wanders, so never hand back a steady level
    always_ff @(posedge clk_i) begin
        flip_q <= !flip_q;
    end

    assign in_pad_o = in_oe_i ? in_drv_i : (pull_en_i ? pull_up_i : flip_q);
    assign out_pad_o = out_oe_i ? out_drv_i : !flip_q;
endmodule

// ==== tb/pug_top_properties.sv ====
// port relations of pug_top: pads, flags, read timing
// assumes sys_rst_i synchronous and active high on clk_i
`timescale 1ns/1ps

module pug_top_chk #(
    parameter int PORTS = 8,
    parameter int PINS = 16,
    parameter bit HAS_SWAP_PORT = 1'b1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [PORTS*PINS-1:0] pin_event_i,
    input wire logic [PORTS*PINS-1:0] pin_event_flag_o,
    input wire logic port_swap_select_o,
    input wire logic scan_in_pad_o,
    input wire logic scan_in_pad_oe_o,
    input wire logic scan_in_pull_en_o,
    input wire logic scan_in_pull_up_o,
    input wire logic scan_in_func_en_o,
    input wire logic scan_out_data_i,
    input wire logic scan_out_drive_i,
    input wire logic scan_out_pad_o,
    input wire logic scan_out_pad_oe_o,
    input wire logic scan_out_weak_drive_o,
    input wire logic scan_out_func_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_in_low;
        scan_in_pad_oe_o |-> !scan_in_pad_o && !scan_in_func_en_o;
    endproperty
    a_in_low: assert property (p_in_low) else $error("scan-in override not low");
    property p_pull_gate;
        scan_in_pad_oe_o |-> !scan_in_pull_en_o && !scan_in_pull_up_o;
    endproperty
    a_pull_gate: assert property (p_pull_gate) else $error("pull on while output");
    property p_pull_up;
        scan_in_pull_up_o |-> scan_in_pull_en_o;
    endproperty
    a_pull_up: assert property (p_pull_up) else $error("pull-up without pull");
    property p_weak_gate;
        scan_out_weak_drive_o |-> scan_out_pad_oe_o;
    endproperty
    a_weak_gate: assert property (p_weak_gate) else $error("weak drive on input");
    property p_out_off;
        scan_out_func_en_o |-> scan_out_pad_oe_o == scan_out_drive_i;
    endproperty
    a_out_off: assert property (p_out_off) else $error("scan-out enable wrong");
    property p_out_data;
        !$past(sys_rst_i) && $past(ce_i) && scan_out_func_en_o && $past(scan_out_func_en_o)
            |-> scan_out_pad_o == $past(scan_out_data_i);
    endproperty
    a_out_data: assert property (p_out_data) else $error("scan-out data not passed");
    property p_flag_set;
        ce_i && (pin_event_i != '0)
            |=> (pin_event_flag_o & $past(pin_event_i)) == $past(pin_event_i);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag not set");
    property p_read_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read answer late");
    property p_rd_upper;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_swap;
        port_swap_select_o |-> HAS_SWAP_PORT;
    endproperty
    a_swap: assert property (p_swap) else $error("swap without second port");

    c_read: cover property (s_axi_arvalid && s_axi_arready);
    c_in_out: cover property (scan_in_pad_oe_o);
    c_weak: cover property (scan_out_weak_drive_o);
endmodule

bind pug_top pug_top_chk #(.PORTS(PORTS), .PINS(PINS), .HAS_SWAP_PORT(HAS_SWAP_PORT)) chk_i (
    .clk_i, .sys_rst_i, .ce_i, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .pin_event_i, .pin_event_flag_o, .port_swap_select_o, .scan_in_pad_o, .scan_in_pad_oe_o,
    .scan_in_pull_en_o, .scan_in_pull_up_o, .scan_in_func_en_o, .scan_out_data_i,
    .scan_out_drive_i, .scan_out_pad_o, .scan_out_pad_oe_o, .scan_out_weak_drive_o,
    .scan_out_func_en_o);

// ==== tb/tb_pug_top.sv ====
// self-checking bench of pug_top through its axi4-lite port and scan pads
// assumes pug_pad_model on the pads and the register map of pug_defines.svh
`timescale 1ns/1ps

module tb_pug_top;
    import pug_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'h0, m;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [127:0] pin_event_i = 128'h0, pin_event_flag_o;
    logic irq_o, ext_bus_clock_gate_o, port_swap_select_o, scan_in_pad_i, scan_in_pad_o;
    logic scan_in_pad_oe_o, scan_in_pull_en_o, scan_in_pull_up_o, scan_in_func_en_o;
    logic scan_in_data_o, scan_out_pad_i, scan_out_pad_o, scan_out_pad_oe_o;
    logic scan_out_data_i = 1'b0, scan_out_drive_i = 1'b0;
    logic scan_out_weak_drive_o, scan_out_func_en_o;
    int errors = 0, tests_run = 0;

    pug_top pug_top_i (.clk_i, .sys_rst_i, .ce_i, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_event_i,
        .pin_event_flag_o, .irq_o, .ext_bus_clock_gate_o, .port_swap_select_o, .scan_in_pad_i,
        .scan_in_pad_o, .scan_in_pad_oe_o, .scan_in_pull_en_o, .scan_in_pull_up_o,
        .scan_in_func_en_o, .scan_in_data_o, .scan_out_data_i, .scan_out_drive_i,
        .scan_out_pad_i, .scan_out_pad_o, .scan_out_pad_oe_o, .scan_out_weak_drive_o,
        .scan_out_func_en_o);
    pug_pad_model pug_pad_model_i (.clk_i, .in_drv_i(scan_in_pad_o), .in_oe_i(scan_in_pad_oe_o),
        .pull_en_i(scan_in_pull_en_o), .pull_up_i(scan_in_pull_up_o),
        .out_drv_i(scan_out_pad_o), .out_oe_i(scan_out_pad_oe_o), .in_pad_o(scan_in_pad_i),
        .out_pad_o(scan_out_pad_i));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic c1(input logic s, input logic e);
        chk({31'h0, s}, {31'h0, e});
    endtask
    // ready is looked at mid-cycle so the edge that moves the item is known
    task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] st,
                      output logic [1:0] r);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, v};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // bready stays high between writes, so back-to-back calls never toggle it
        s_axi_bready <= 1'b1;
        forever begin
            @(negedge clk_i);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge clk_i);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) return;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar, b;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(negedge clk_i);
            ar = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid && s_axi_rready;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ar) s_axi_arvalid <= 1'b0;
            if (b) return;
        end
    endtask
    task automatic wc(input logic [7:0] a, input logic [15:0] v, input logic [3:0] st);
        wr(a, v, st, rs);
        chk({30'h0, rs}, 32'h0);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, d, rs);
        chk({30'h0, rs}, 32'h0);
        chk(d, e);
    endtask
    task automatic ev(input int b);
        pin_event_i[b] <= 1'b1;
        @(posedge clk_i);
        pin_event_i <= 128'h0;
        @(posedge clk_i);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        c1(ext_bus_clock_gate_o, 1'b1);
        rc(8'h04, 32'h2);
        rc(8'h08, 32'h0);
        rc(8'h0c, 32'h0);
        wc(8'h04, 16'hffff, 4'h3);
        rc(8'h04, 32'h3);
        c1(port_swap_select_o, 1'b1);
        wc(8'h04, 16'h0000, 4'h3);
        c1(ext_bus_clock_gate_o, 1'b0);
        c1(port_swap_select_o, 1'b0);
        wc(8'h00, 16'hffff, 4'h3);
        rc(8'h00, 32'h0);
        // frozen by ce_i low, an event pulse must leave no flag behind
        ce_i <= 1'b0;
        ev(5);
        c1(pin_event_flag_o[5], 1'b0);
        ce_i <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            ev(p * 16 + p);
            ev(p * 16 + 15);
            c1(pin_event_flag_o[p * 16 + p], 1'b1);
            rc(8'h00, 32'h1 << p);
            wc(8'h20 + 8'(4 * p), 16'h1 << p, 4'h3);
            rc(8'h20 + 8'(4 * p), 32'h8000);
            rc(8'h00, 32'h1 << p);
            // unstrobed upper lane must not clear
            wc(8'h20 + 8'(4 * p), 16'h8000, 4'h1);
            rc(8'h20 + 8'(4 * p), 32'h8000);
            wc(8'h20 + 8'(4 * p), 16'h8000, 4'h3);
            rc(8'h00, 32'h0);
        end
        rc(8'h10, 32'hff);
        c1(irq_o, 1'b0);
        wc(8'h14, 16'h0004, 4'h3);
        c1(irq_o, 1'b1);
        wc(8'h10, 16'h0004, 4'h3);
        c1(irq_o, 1'b0);
        rc(8'h10, 32'hfb);
        for (int i = 0; i < 8; i++) begin
            m = 4'(i);
            wc(8'h08, {9'h0, m[2], 2'h0, m[1:0], 2'h0}, 4'h3);
            repeat (4) @(posedge clk_i);
            c1(scan_in_pull_en_o, m[1] & !m[2]);
            c1(scan_in_pull_up_o, m[1] & m[0] & !m[2]);
            c1(scan_in_pad_oe_o, m[2]);
            c1(scan_in_func_en_o, !m[2]);
            if (m[2] || m[1]) c1(scan_in_data_o, m[0] & !m[2]);
        end
        wc(8'h08, 16'hffff, 4'h3);
        rc(8'h08, 32'h4c);
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            scan_out_drive_i <= m[0];
            scan_out_data_i <= m[1];
            wc(8'h0c, {9'h0, m[2], 1'b0, m[3], 4'h0}, 4'h3);
            repeat (2) @(posedge clk_i);
            c1(scan_out_func_en_o, !m[2]);
            c1(scan_out_pad_oe_o, m[0] & !m[2]);
            c1(scan_out_weak_drive_o, m[3] & m[0] & !m[2]);
            if (!m[2]) c1(scan_out_pad_o, m[1]);
        end
        wc(8'h0c, 16'hffff, 4'h3);
        rc(8'h0c, 32'h50);
        wr(8'h18, 16'h1234, 4'h3, rs);
        chk({30'h0, rs}, 32'h2);
        rd(8'h05, d, rs);
        chk({30'h0, rs}, 32'h2);
        chk(d, 32'h0);
        close_out();
    end
endmodule
